// ### rtl/rci_map.svh
// Purpose: offsets, field positions and reset values of the reset block
// Assumes: 32-bit apb data, one aligned word per register
// Notes: included by the reset cause module
`ifndef RCI_MAP_SVH
`define RCI_MAP_SVH

`define RCI_OFS_EVT_STS 12'h000
`define RCI_OFS_EVT_EN 12'h004
`define RCI_OFS_EVT_CLR 12'h008
`define RCI_OFS_POWER_CONTROL_REG 12'h00c
`define RCI_OFS_STATUS 12'h010
`define RCI_OFS_OPTION 12'h014
`define RCI_OFS_PORT_A_DIRECTION 12'h018
`define RCI_OFS_PORT_B_DIRECTION 12'h01c
`define RCI_OFS_IRQ_CONTROL_REG 12'h020
`define RCI_OFS_PC_HIGH_LATCH 12'h024
`define RCI_OFS_PC 12'h028

`define RCI_POWER_CONTROL_REG_BOR 0
`define RCI_POWER_CONTROL_REG_POR 1
`define RCI_POWER_CONTROL_REG_PER 2
`define RCI_STATUS_TO 4
`define RCI_STATUS_PD 3
`define RCI_GIE_BIT 7

`define RCI_EV_POR 0
`define RCI_EV_BOR 1
`define RCI_EV_PER 2
`define RCI_EV_WDT_RST 3
`define RCI_EV_MASTER_CLEAR_PIN 4
`define RCI_EV_WDT_WAKE 5
`define RCI_EV_IRQ_WAKE 6

`define RCI_PC_RESET 13'h0000
`define RCI_PC_VECTOR 13'h0004
`define RCI_PC_STEP 13'h0001
`define RCI_STATUS_POR 8'h18
`define RCI_OPTION_RST 8'hff
`define RCI_PORT_A_DIRECTION_RST 5'h1f
`define RCI_PORT_B_DIRECTION_RST 8'hff
`define RCI_POWER_CONTROL_REG_RST_PAR 8'h04
`define RCI_POWER_CONTROL_REG_RST_NOPAR 8'h00

`endif

// ### rtl/rci_pkg.sv
// Purpose: types shared by the reset cause block and its bench
// Assumes: apb with 12-bit address and 32-bit data
// Notes: offsets and reset values live in rci_map.svh
package rci_pkg;

   typedef struct packed {
      logic psel;
      logic penable;
      logic pwrite;
      logic [11:0] paddr;
      logic [31:0] pwdata;
   } rci_apb_req_t;

   typedef struct packed {
      logic pready;
      logic [31:0] prdata;
      logic pslverr;
   } rci_apb_rsp_t;

   typedef enum logic [3:0] {
      CAUSE_NONE,
      CAUSE_POR,
      CAUSE_BOR,
      CAUSE_PER,
      CAUSE_WDT_RST,
      CAUSE_WDT_WAKE,
      CAUSE_MASTER_CLEAR_PIN_RUN,
      CAUSE_MASTER_CLEAR_PIN_SLP,
      CAUSE_IRQ_WAKE
   } rci_cause_t;

   typedef struct packed {
      logic [3:0] s1;
      logic [3:0] s2;
      logic [3:0] s3;
      logic [3:0] st;
      logic [7:0] power_control_reg;
      logic [7:0] status;
      logic [7:0] option;
      logic [4:0] port_a_direction;
      logic [7:0] port_b_direction;
      logic [7:0] irq_control_reg;
      logic [4:0] pc_high_latch;
      logic [12:0] pc;
      logic pc_load;
      logic [6:0] evt;
      logic [6:0] ien;
      logic irq;
      logic pready;
      logic [31:0] prdata;
      logic pslverr;
   } rci_state_t;

endpackage : rci_pkg

// ### rtl/rci_reset_init.sv
// Purpose: records the reset or wake-up cause and applies initial values
// Assumes: detector, watchdog and clear pin inputs are asynchronous
// Notes: time-out delays are outside this block; it loads vector 0004h on irq wake with the global enable set, else pc+1
// Functional notes
// RQ1 - power-on reset sets the timeout flag to one
// RQ2 - power-on reset sets the powerdown flag to one
// RQ3 - parity build: power-on reset sets the parity fault flag
// RQ4 - brown-out reset leaves the parity fault flag at one
// RQ5 - flag combinations identify each reset or wake-up cause
// RQ6 - running clear: pc zero, upper status cleared, other flags kept
// RQ7 - clear in sleep or irq wake: timeout one, powerdown zero
// RQ8 - watchdog reset: pc zero, status 0000 1uuu; wake: uuu0 0uuu
// RQ9 - irq wake with global enable loads vector 0004h, else pc+1
// RQ10 - power control: power-on u10x, brown-out uuu0, parity u0uu
// RQ11 - resets load option, port directions, irq control, pc latch
// RQ12 - build option removes the power control register
// RQ13 - reduced build ignores brown-out and has no brown-out flag
// RQ14 - wake-up event sets at least one irq control flag
// RQ15 - simultaneous requests: power-on, brown-out, parity, watchdog, clear
// RQ16 - bits unknown after power-on are reset to zero
// RQ17 - power control bits: brown-out 0, power-on 1, parity 2
// RQ18 - software writes cause flags back to one after each reset
`timescale 1ns/100ps
`include "rci_map.svh"

module rci_reset_init
   import rci_pkg::*;
#(
   parameter bit HAS_POWER_CONTROL_REG = 1'b1,
   parameter bit HAS_BOR = 1'b1,
   parameter bit HAS_PARITY = 1'b1
)
(
   input wire logic i_core_clk,
   input wire logic i_arst_n,
   input wire rci_apb_req_t i_apb,
   input wire logic i_por_det,
   input wire logic i_bor_det,
   input wire logic i_wdt_timeout,
   input wire logic i_master_clear_pin_n,
   input wire logic i_parity_err,
   input wire logic i_sleeping,
   input wire logic i_irq_wake,
   input wire logic [7:0] i_wake_flags,
   input wire logic [12:0] i_pc_now,
   output rci_apb_rsp_t o_apb,
   output logic [7:0] o_power_control_reg,
   output logic [7:0] o_status,
   output logic [7:0] o_option,
   output logic [4:0] o_port_a_direction,
   output logic [7:0] o_port_b_direction,
   output logic [7:0] o_irq_control_reg,
   output logic [4:0] o_pc_high_latch,
   output logic [12:0] o_pc,
   output logic o_pc_load,
   output logic o_irq
);

   // each flag bit exists only where its source is built in
   localparam bit FLAG_BRN_ON = HAS_POWER_CONTROL_REG && HAS_BOR; // [RQ13]
   localparam bit FLAG_PWR_ON = HAS_POWER_CONTROL_REG; // [RQ12]
   localparam bit FLAG_PAR_ON = HAS_POWER_CONTROL_REG && HAS_PARITY; // [RQ12]
   localparam logic [7:0] FLAG_MASK =
      {5'h00, FLAG_PAR_ON, FLAG_PWR_ON, FLAG_BRN_ON}; // [RQ17]
   localparam logic [7:0] FLAG_RST =
      FLAG_PAR_ON ? `RCI_POWER_CONTROL_REG_RST_PAR : `RCI_POWER_CONTROL_REG_RST_NOPAR;

   localparam rci_state_t ST_RST = '{
      s1: 4'h0,
      s2: 4'h0,
      s3: 4'h0,
      st: 4'h0,
      power_control_reg: FLAG_RST,
      status: `RCI_STATUS_POR,
      option: `RCI_OPTION_RST,
      port_a_direction: `RCI_PORT_A_DIRECTION_RST,
      port_b_direction: `RCI_PORT_B_DIRECTION_RST,
      irq_control_reg: 8'h00,
      pc_high_latch: 5'h00,
      pc: `RCI_PC_RESET,
      pc_load: 1'b0,
      evt: 7'h00,
      ien: 7'h00,
      irq: 1'b0,
      pready: 1'b0,
      prdata: 32'h0000_0000,
      pslverr: 1'b0
   };

   rci_state_t q;
   rci_state_t next_q;
   rci_cause_t cause;
   logic [3:0] agree;
   logic [3:0] rise;
   logic [31:0] rd;
   logic hit;
   logic access;
   logic init;
   logic keep_int0;
   logic global_irq_enable;
   logic [6:0] ev;
   logic [6:0] clr;
   logic [12:0] wake_pc;

   always_comb
   begin
      rd = 32'h0000_0000;
      hit = 1'b1;
      init = 1'b0;
      keep_int0 = 1'b0;
      ev = 7'h00;
      clr = 7'h00;
      global_irq_enable = q.irq_control_reg[`RCI_GIE_BIT];
      access = i_apb.psel & i_apb.penable;
      next_q = q;
      // wraps within the 13-bit program space
      wake_pc = i_pc_now + `RCI_PC_STEP;
      next_q.s1[0] = i_por_det;
      // reduced build: the brown-out stage never leaves zero
      next_q.s1[1] = i_bor_det & HAS_BOR; // [RQ13]
      next_q.s1[2] = i_wdt_timeout;
      // clear pin is active low; inverted ahead of the first stage
      next_q.s1[3] = ~i_master_clear_pin_n;
      next_q.s2 = q.s1;
      next_q.s3 = q.s2;
      // a change counts once stages two and three agree
      agree = ~(q.s2 ^ q.s3);
      // only the asserting edge starts an event; the release is silent
      rise = agree & q.s3 & ~q.st;
      // filtered level moves only on agreement, so a one-stage glitch
      // never reaches the cause logic
      next_q.st = (agree & q.s3) | (~agree & q.st);
      next_q.pc_load = 1'b0;

      // one winner per cycle; losers in the same cycle are dropped
      if (rise[0])
      begin
         cause = CAUSE_POR; // [RQ15]
      end
      else if (rise[1] && HAS_BOR)
      begin
         cause = CAUSE_BOR; // [RQ13]
      end
      else if (i_parity_err && HAS_PARITY)
      begin
         cause = CAUSE_PER;
      end
      else if (rise[2])
      begin
         cause = i_sleeping ? CAUSE_WDT_WAKE : CAUSE_WDT_RST;
      end
      else if (rise[3])
      begin
         cause = i_sleeping ? CAUSE_MASTER_CLEAR_PIN_SLP : CAUSE_MASTER_CLEAR_PIN_RUN;
      end
      else if (i_irq_wake && i_sleeping)
      begin
         cause = CAUSE_IRQ_WAKE;
      end
      else
      begin
         cause = CAUSE_NONE;
      end

      case (i_apb.paddr)
         `RCI_OFS_EVT_STS: rd = {25'h000_0000, q.evt};
         `RCI_OFS_EVT_EN: rd = {25'h000_0000, q.ien};
         `RCI_OFS_EVT_CLR: rd = 32'h0000_0000;
         `RCI_OFS_POWER_CONTROL_REG: rd = {24'h00_0000, q.power_control_reg};
         `RCI_OFS_STATUS: rd = {24'h00_0000, q.status};
         `RCI_OFS_OPTION: rd = {24'h00_0000, q.option};
         `RCI_OFS_PORT_A_DIRECTION: rd = {27'h000_0000, q.port_a_direction};
         `RCI_OFS_PORT_B_DIRECTION: rd = {24'h00_0000, q.port_b_direction};
         `RCI_OFS_IRQ_CONTROL_REG: rd = {24'h00_0000, q.irq_control_reg};
         `RCI_OFS_PC_HIGH_LATCH: rd = {27'h000_0000, q.pc_high_latch};
         `RCI_OFS_PC: rd = {19'h0_0000, q.pc};
         default: hit = 1'b0;
      endcase

      // one wait state; pready and read data come from flops
      if (access && !q.pready)
      begin
         next_q.pready = 1'b1;
         next_q.prdata = rd;
         next_q.pslverr = ~hit;
      end
      else
      begin
         next_q.pready = 1'b0;
         next_q.pslverr = 1'b0;
      end

      // software writes first so that a hardware event the same cycle wins
      if (access && q.pready && i_apb.pwrite)
      begin
         case (i_apb.paddr)
            `RCI_OFS_EVT_STS, `RCI_OFS_PC:
            begin
               // hardware-owned words: a write is taken and dropped
               clr = 7'h00;
            end
            `RCI_OFS_EVT_EN: next_q.ien = i_apb.pwdata[6:0];
            `RCI_OFS_EVT_CLR: clr = i_apb.pwdata[6:0];
            `RCI_OFS_POWER_CONTROL_REG: next_q.power_control_reg = i_apb.pwdata[7:0]; // [RQ18]
            `RCI_OFS_STATUS:
            begin
               // timeout and powerdown are hardware-only
               next_q.status[7:5] = i_apb.pwdata[7:5];
               next_q.status[2:0] = i_apb.pwdata[2:0];
            end
            `RCI_OFS_OPTION: next_q.option = i_apb.pwdata[7:0];
            `RCI_OFS_PORT_A_DIRECTION: next_q.port_a_direction = i_apb.pwdata[4:0];
            `RCI_OFS_PORT_B_DIRECTION: next_q.port_b_direction = i_apb.pwdata[7:0];
            `RCI_OFS_IRQ_CONTROL_REG: next_q.irq_control_reg = i_apb.pwdata[7:0];
            `RCI_OFS_PC_HIGH_LATCH: next_q.pc_high_latch = i_apb.pwdata[4:0];
            default:
            begin
               clr = 7'h00;
            end
         endcase
      end

      // only the winner's flag updates are applied
      unique case (cause)
         CAUSE_NONE:
         begin
            init = 1'b0;
         end
         CAUSE_POR:
         begin
            ev[`RCI_EV_POR] = 1'b1;
            init = 1'b1;
            // unknown low status bits come out zero
            next_q.status = `RCI_STATUS_POR; // [RQ1] [RQ2] [RQ16]
            next_q.power_control_reg[`RCI_POWER_CONTROL_REG_PER] = 1'b1; // [RQ3] [RQ10]
            next_q.power_control_reg[`RCI_POWER_CONTROL_REG_POR] = 1'b0; // [RQ17]
            next_q.power_control_reg[`RCI_POWER_CONTROL_REG_BOR] = 1'b0; // [RQ16]
         end
         CAUSE_BOR:
         begin
            ev[`RCI_EV_BOR] = 1'b1;
            init = 1'b1;
            next_q.status[7:3] = 5'h03;
            next_q.power_control_reg[`RCI_POWER_CONTROL_REG_BOR] = 1'b0; // [RQ10] [RQ5]
            next_q.power_control_reg[`RCI_POWER_CONTROL_REG_PER] = 1'b1; // [RQ4]
         end
         CAUSE_PER:
         begin
            ev[`RCI_EV_PER] = 1'b1;
            init = 1'b1;
            next_q.status[`RCI_STATUS_TO] = 1'b1; // [RQ5]
            next_q.status[`RCI_STATUS_PD] = 1'b1;
            next_q.power_control_reg[`RCI_POWER_CONTROL_REG_PER] = 1'b0; // [RQ10]
         end
         CAUSE_WDT_RST:
         begin
            ev[`RCI_EV_WDT_RST] = 1'b1;
            init = 1'b1;
            keep_int0 = 1'b1;
            next_q.status[7:3] = 5'h01; // [RQ8]
         end
         CAUSE_WDT_WAKE:
         begin
            ev[`RCI_EV_WDT_WAKE] = 1'b1;
            next_q.status[4:3] = 2'b00; // [RQ8] [RQ5]
            next_q.irq_control_reg = q.irq_control_reg | i_wake_flags; // [RQ14]
            next_q.pc = wake_pc;
            next_q.pc_load = 1'b1;
         end
         CAUSE_MASTER_CLEAR_PIN_RUN:
         begin
            ev[`RCI_EV_MASTER_CLEAR_PIN] = 1'b1;
            init = 1'b1;
            keep_int0 = 1'b1;
            next_q.status[7:5] = 3'b000; // [RQ6]
         end
         CAUSE_MASTER_CLEAR_PIN_SLP:
         begin
            ev[`RCI_EV_MASTER_CLEAR_PIN] = 1'b1;
            init = 1'b1;
            keep_int0 = 1'b1;
            next_q.status[7:3] = 5'h02; // [RQ7]
         end
         CAUSE_IRQ_WAKE:
         begin
            ev[`RCI_EV_IRQ_WAKE] = 1'b1;
            next_q.status[4:3] = 2'b10; // [RQ7]
            next_q.irq_control_reg = q.irq_control_reg | i_wake_flags; // [RQ14]
            // vector only when the global enable was set before waking
            next_q.pc = global_irq_enable ? `RCI_PC_VECTOR : wake_pc; // [RQ9]
            next_q.pc_load = 1'b1;
         end
      endcase

      // every full reset shares one set of initial values
      if (init)
      begin
         next_q.pc = `RCI_PC_RESET; // [RQ6] [RQ8]
         next_q.pc_load = 1'b1;
         next_q.option = `RCI_OPTION_RST; // [RQ11]
         next_q.port_a_direction = `RCI_PORT_A_DIRECTION_RST;
         next_q.port_b_direction = `RCI_PORT_B_DIRECTION_RST;
         next_q.pc_high_latch = 5'h00;
         // the low flag bit survives clear and watchdog resets
         next_q.irq_control_reg = {7'h00, keep_int0 & q.irq_control_reg[0]}; // [RQ16]
      end

      // absent bits read as zero in reduced builds
      next_q.power_control_reg = next_q.power_control_reg & FLAG_MASK; // [RQ12] [RQ13]

      // a new event wins over a clear in the same cycle
      next_q.evt = (q.evt & ~clr) | ev;
      next_q.irq = |(next_q.evt & next_q.ien);
   end

   always_ff @(posedge i_core_clk or negedge i_arst_n)
   begin
      if (!i_arst_n)
      begin
         q <= ST_RST;
      end
      else
      begin
         q <= next_q;
      end
   end

   assign o_apb.pready = q.pready;
   assign o_apb.prdata = q.prdata;
   assign o_apb.pslverr = q.pslverr;
   assign o_power_control_reg = q.power_control_reg;
   assign o_status = q.status;
   assign o_option = q.option;
   assign o_port_a_direction = q.port_a_direction;
   assign o_port_b_direction = q.port_b_direction;
   assign o_irq_control_reg = q.irq_control_reg;
   assign o_pc_high_latch = q.pc_high_latch;
   assign o_pc = q.pc;
   assign o_pc_load = q.pc_load;
   assign o_irq = q.irq;

endmodule : rci_reset_init

// ### test/rci_chk.sv
// Purpose: assertions on the reset cause block
// Assumes: slow inputs act 3 edges after they are first sampled high
// Notes: bound below the module
`timescale 1ns/100ps
module rci_chk
   import rci_pkg::*;
#(parameter bit HAS_PARITY = 1'b1)
(
   input wire logic i_core_clk,
   input wire logic i_arst_n,
   input wire rci_apb_req_t i_apb,
   input wire rci_apb_rsp_t o_apb,
   input wire logic i_por_det,
   input wire logic i_bor_det,
   input wire logic i_wdt_timeout,
   input wire logic i_master_clear_pin_n,
   input wire logic i_parity_err,
   input wire logic i_sleeping,
   input wire logic i_irq_wake,
   input wire logic [7:0] i_wake_flags,
   input wire logic [12:0] i_pc_now,
   input wire logic [7:0] o_power_control_reg,
   input wire logic [7:0] o_status,
   input wire logic [7:0] o_option,
   input wire logic [7:0] o_irq_control_reg,
   input wire logic [12:0] o_pc
);
   default clocking @(posedge i_core_clk); endclocking
   default disable iff (!i_arst_n);
   // no stronger cause lands now and no register write takes effect
   sequence s_calm;
      !$past(i_por_det, 3) && !$past(i_bor_det, 3) && !o_apb.pready &&
      !$past(i_wdt_timeout, 3) && $past(i_master_clear_pin_n, 3);
   endsequence
   sequence s_par;
      s_calm ##0 (HAS_PARITY && i_parity_err);
   endsequence
   sequence s_irq;
      s_calm ##0 (i_irq_wake && i_sleeping && !i_parity_err);
   endsequence
   a_par_cause: assert property (s_par |=>
      !o_power_control_reg[2] && $stable(o_power_control_reg[1:0])) else $error("parity cause");
   a_par_init: assert property (s_par |=> o_pc == 13'h0 &&
      o_option == 8'hff && o_irq_control_reg == 8'h0) else $error("parity init");
   a_irq_vec: assert property (s_irq ##0 o_irq_control_reg[7] |=>
      o_pc == 13'h4) else $error("vector");
   a_irq_next: assert property (s_irq ##0 !o_irq_control_reg[7] |=>
      o_pc == $past(i_pc_now) + 13'h1) else $error("next pc");
   a_irq_flags: assert property (s_irq |=>
      o_status[4:3] == 2'h2 && $stable(o_power_control_reg)) else $error("wake flags");
   a_wake_keep: assert property (s_irq |=> $stable(o_option))
      else $error("wake keep");
   a_wake_set: assert property (s_irq |=>
      (o_irq_control_reg & $past(i_wake_flags)) == $past(i_wake_flags))
      else $error("wake set");
   a_apb_once: assert property (o_apb.pready |=> !o_apb.pready)
      else $error("pready held");
   c_par: cover property (s_par);
   c_vec: cover property (s_irq ##0 o_irq_control_reg[7]);
   c_err: cover property (o_apb.pready && o_apb.pslverr);
endmodule : rci_chk
bind rci_reset_init rci_chk #(.HAS_PARITY(HAS_PARITY)) u_chk (.i_core_clk,
   .i_arst_n, .i_apb, .o_apb, .i_por_det, .i_bor_det, .i_wdt_timeout,
   .i_master_clear_pin_n, .i_parity_err, .i_sleeping, .i_irq_wake, .i_wake_flags,
   .i_pc_now, .o_power_control_reg, .o_status, .o_option, .o_irq_control_reg, .o_pc);

// ### test/rci_src_model.sv
// Purpose: reset sources and wake requests around the block
// Assumes: detector lines are slow, pulses last one cycle
// Notes: kind 8 raises parity and irq wake together
`timescale 1ns/100ps
module rci_src_model
(
   input wire logic i_core_clk,
   output logic o_por_det,
   output logic o_bor_det,
   output logic o_watchdog,
   output logic o_clear_n,
   output logic o_parity_err,
   output logic o_irq_wake
);
   initial {o_por_det, o_bor_det, o_watchdog, o_parity_err, o_irq_wake,
      o_clear_n} = 6'h01;
   // slow lines held 3 edges so the 3-stage sync cannot miss them
   task fire(input int k);
      @(posedge i_core_clk);
      o_por_det <= k == 0;
      o_bor_det <= k == 1;
      o_watchdog <= k == 3 || k == 5;
      o_clear_n <= !(k == 4 || k == 7);
      o_parity_err <= k == 2 || k == 8;
      o_irq_wake <= k >= 6 && k != 7;
      @(posedge i_core_clk);
      {o_parity_err, o_irq_wake} <= 2'h0;
      repeat (2) @(posedge i_core_clk);
      {o_por_det, o_bor_det, o_watchdog, o_clear_n} <= 4'h1;
   endtask : fire
endmodule : rci_src_model

// ### test/testbench.sv
// Purpose: self-checking bench for the reset cause block
// Assumes: apb answers after one wait state
// Notes: kinds 0 por 1 bor 2 parity 3 dog 4 clear 5 dog wake 6 irq 7 clear
`timescale 1ns/100ps
`include "rci_map.svh"
module testbench
   import rci_pkg::*;
;
   logic i_core_clk = 1'b0;
   logic i_arst_n = 1'b0;
   logic i_sleeping = 1'b0;
   logic [7:0] i_wake_flags = 8'h0;
   logic [12:0] i_pc_now = 13'h0;
   rci_apb_req_t i_apb = '0;
   rci_apb_rsp_t o_apb;
   logic i_por_det, i_bor_det, i_wdt_timeout, i_master_clear_pin_n, i_parity_err;
   logic i_irq_wake, o_irq, o_pc_load, e;
   logic [7:0] o_power_control_reg, o_status, o_option, o_port_b_direction, o_irq_control_reg;
   logic [12:0] o_pc;
   logic [4:0] o_port_a_direction, o_pc_high_latch;
   logic [31:0] r, v;
   int bad_count = 0, n_checks = 0, seed = 26;
   int st, pcn, ov, tb, ic, mpc, k, ta, pl, l0, loads = 0;
   always #20 i_core_clk = ~i_core_clk;
   // counts pc load pulses; each event must give exactly one
   always @(posedge i_core_clk)
      if (o_pc_load === 1'b1)
         loads <= loads + 1;
   rci_reset_init u_rci_reset_init (.i_core_clk, .i_arst_n, .i_apb,
      .i_por_det, .i_bor_det, .i_wdt_timeout, .i_master_clear_pin_n, .i_parity_err,
      .i_sleeping, .i_irq_wake, .i_wake_flags, .i_pc_now, .o_apb, .o_power_control_reg,
      .o_status, .o_option, .o_port_a_direction, .o_port_b_direction, .o_irq_control_reg, .o_pc_high_latch,
      .o_pc, .o_pc_load, .o_irq);
   rci_src_model u_rci_src_model (.i_core_clk, .o_por_det(i_por_det),
      .o_bor_det(i_bor_det), .o_watchdog(i_wdt_timeout),
      .o_clear_n(i_master_clear_pin_n), .o_parity_err(i_parity_err),
      .o_irq_wake(i_irq_wake));
   task tally_and_finish;
      $display("checks %0d mismatches %0d", n_checks, bad_count);
      if (bad_count == 0 && n_checks > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask : tally_and_finish
   task chk(input logic [31:0] got, input int exp);
      n_checks++;
      if (got !== 32'(exp))
      begin
         bad_count++;
         $display("unexpected at %0t got %h exp %h", $time, got, exp);
      end
   endtask : chk
   task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      int n;
      i_apb <= '{1'b1, 1'b0, w, a, d};
      @(posedge i_core_clk);
      i_apb.penable <= 1'b1;
      for (n = 0; n < 20 && o_apb.pready !== 1'b1; n++)
         @(posedge i_core_clk);
      r = o_apb.prdata;
      e = o_apb.pslverr;
      i_apb <= '0;
      // registered irq follows an enable write on the write's own edge; two edges are waited
      repeat (2) @(posedge i_core_clk);
      if (n == 20)
      begin
         bad_count++;
         tally_and_finish;
      end
   endtask : apb
   task model(input int k);
      logic rs;
      rs = k < 5 || k == 7;
      case (k)
         0: st = 8'h18;
         1: st = st & 8'h07 | 8'h18;
         2: st = st | 8'h18;
         3: st = st & 8'h07 | 8'h08;
         4: st = st & 8'h1f;
         5: st = st & 8'he7;
         6: st = st & 8'he7 | 8'h10;
         default: st = st & 8'h07 | 8'h10;
      endcase
      pcn = k == 0 ? 4 : k == 1 ? pcn & 6 | 4 : k == 2 ? pcn & 3 : pcn;
      mpc = rs ? 0 : k == 6 && ic[7] ? 4 : (i_pc_now + 1) & 32'h1fff;
      ic = rs ? (k == 3 || k == 4 || k == 7 ? ic & 1 : 0) : ic | i_wake_flags;
      ov = rs ? 8'hff : ov;
      tb = rs ? 8'hff : tb;
      ta = rs ? 'h1f : ta;
      pl = rs ? 0 : pl;
   endtask : model
   task check_all;
      chk(32'(o_status), st);
      chk(32'(o_power_control_reg), pcn);
      chk(32'(o_option), ov);
      chk(32'(o_port_b_direction), tb);
      chk(32'(o_port_a_direction), ta);
      chk(32'(o_pc_high_latch), pl);
      chk(32'(o_irq_control_reg), ic);
      chk(32'(o_pc), mpc);
   endtask : check_all
   initial
   begin
      #400_000;
      bad_count++;
      tally_and_finish;
   end
   initial
   begin
      repeat (6) @(posedge i_core_clk);
      i_arst_n <= 1'b1;
      model(0);
      check_all;
      apb(1'b0, 12'h100, 32'h0);
      chk(32'(e), 1);
      chk(r, 0);
      $display("test reset done");
      apb(1'b1, `RCI_OFS_EVT_EN, 32'h7f);
      for (int i = 0; i < 24; i++)
      begin
         k = i < 9 ? i : i == 9 ? 6 : $unsigned($random(seed)) % 8;
         apb(1'b1, `RCI_OFS_POWER_CONTROL_REG, 32'h7);
         pcn = 7;
         v = $random(seed);
         apb(1'b1, `RCI_OFS_OPTION, v);
         apb(1'b1, `RCI_OFS_PORT_A_DIRECTION, v);
         apb(1'b1, `RCI_OFS_PORT_B_DIRECTION, v);
         apb(1'b1, `RCI_OFS_PC_HIGH_LATCH, v);
         ov = v[7:0];
         ta = v[4:0];
         tb = v[7:0];
         pl = v[4:0];
         v[7] = i[0];
         apb(1'b1, `RCI_OFS_IRQ_CONTROL_REG, v);
         ic = v[7:0];
         apb(1'b1, `RCI_OFS_STATUS, v);
         st = v & 8'he7 | st & 8'h18;
         i_sleeping <= k > 4;
         i_pc_now <= 13'($random(seed));
         i_wake_flags <= 8'($random(seed));
         l0 = loads;
         u_rci_src_model.fire(k);
         repeat (4) @(posedge i_core_clk);
         model(k == 8 ? 2 : k);
         check_all;
         chk(32'(loads - l0), 1);
         apb(1'b0, `RCI_OFS_EVT_STS, 32'h0);
         chk(r, 1 << (k == 8 ? 2 : k == 7 ? 4 : k));
         chk(32'(o_irq), 1);
         apb(1'b1, `RCI_OFS_EVT_EN, 32'h0);
         chk(32'(o_irq), 0);
         apb(1'b1, `RCI_OFS_EVT_EN, 32'h7f);
         apb(1'b1, `RCI_OFS_EVT_CLR, 32'h7f);
         chk(32'(o_irq), 0);
         i_sleeping <= 1'b0;
         $display("test %0d kind %0d done", i, k);
      end
      tally_and_finish;
   end
endmodule : testbench
